/* File: rtl/padc_pkg.sv */
// constants and carrier types for the pipelined converter output logic
// What this block does
// - every rising conversion clock edge starts conversion
// - both inputs sampled together into pipeline
// - result valid at third rising edge
// - one conversion per cycle, latency three
// - twelve bit two's complement, msb highest
// - overflow high only at extreme codes
// - idle timer refreshes dynamic logic when stopped
// - gain select high unity, low double
`default_nettype none
package padc_pkg;
    localparam int unsigned DATA_W        = 12;               // result width
    localparam int unsigned LATENCY       = 3;                // conversion edges to output
    localparam int unsigned CLK_HZ        = 10_000_000;       // system clock rate
    localparam int unsigned IDLE_US       = 1000;             // idle refresh interval, 1 ms
    localparam int unsigned IDLE_CYC      = IDLE_US * (CLK_HZ / 1_000_000); // cycles in idle interval
    localparam int unsigned MIN_RATE_HZ   = 20_000;           // slowest accurate conversion rate
    localparam logic [11:0] CODE_MAX      = 12'h7ff;          // most positive code
    localparam logic [11:0] CODE_MIN      = 12'h800;          // most negative code
    localparam logic [11:0] RESULT_RST    = 12'h000;          // result after reset

    // one analog sample as the core sees it
    typedef struct packed {
        logic signed [12:0] pos;  // positive input, digitised
        logic signed [12:0] neg;  // negative input, digitised
    } padc_sample_t;

    // output word with its flag
    typedef struct packed {
        logic [11:0] result_bits;
        logic        overflow_flag;
    } padc_out_t;
endpackage
`default_nettype wire

/* File: rtl/padc_stage.sv */
// one pipeline stage register of the converter
`default_nettype none
module padc_stage #(
    parameter int unsigned W = 12
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // advance strobe and data
    input  wire logic         adv,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] data_q;  // held stage value
    logic [W-1:0] data_d;  // next stage value

    // move on each conversion start only
    always_comb begin
        data_d = adv ? din : data_q;
    end

    // register the stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_q <= '0;
        end else begin
            data_q <= data_d;
        end
    end

    assign dout = data_q;
endmodule
`default_nettype wire

/* File: rtl/padc_top.sv */
// conversion timing, pipeline, overflow and idle refresh for the converter
`default_nettype none
module padc_top #(
    parameter int unsigned IDLE_CYCLES = padc_pkg::IDLE_CYC  // idle refresh interval in cycles
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // conversion clock from capture logic, sampled
    input  wire logic                conv_clk,
    // gain select, high unity, low double
    input  wire logic                gain_sel,
    // digitised analog inputs
    input  wire logic signed [12:0]  ain_pos,
    input  wire logic signed [12:0]  ain_neg,
    // result outputs
    output logic [11:0]              result_bits,
    output logic                     overflow_flag,
    // refresh strobe, one cycle
    output logic                     refresh
);
    localparam int unsigned W = padc_pkg::DATA_W;

    // edge detect on conversion clock
    logic conv_prev_q;
    logic conv_prev_d;
    logic start;      // rising edge seen
    assign start = conv_clk & ~conv_prev_q;

    // next value of the edge detector: the level seen this cycle
    always_comb begin
        conv_prev_d = conv_clk;
    end

    // register the previous level; reset to the idle low level so that
    // no false start follows reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_prev_q <= 1'b0;
        end else begin
            conv_prev_q <= conv_prev_d;
        end
    end

    // sample both inputs together, apply gain, saturate;
    // the core halves the difference so that a full 13-bit swing spans the code
    // at unity gain, and double gain skips that halving
    padc_pkg::padc_sample_t smp;
    logic signed [14:0] diff;    // differential input, gain applied
    logic        [W-1:0] code;   // saturated code
    always_comb begin
        smp.pos = ain_pos;
        smp.neg = ain_neg;
        diff = 15'(smp.pos) - 15'(smp.neg);
        if (!gain_sel) begin
            diff = diff <<< 1;  // gain of two halves span
        end
        diff = diff >>> 1;  // unity gain spans the core
        if (diff > 15'sd2047) begin
            code = padc_pkg::CODE_MAX;
        end else if (diff < -15'sd2048) begin
            code = padc_pkg::CODE_MIN;
        end else begin
            code = diff[W-1:0];  // two's complement
        end
    end

    // two held stages plus the output register give three starts of latency;
    // one more stage would push the word past its capture edge
    logic [W-1:0] stg [0:padc_pkg::LATENCY-1];  // stg[0] is the fresh code
    assign stg[0] = code;
    genvar gi;
    generate
        for (gi = 0; gi < padc_pkg::LATENCY - 1; gi++) begin : g_stage
            padc_stage #(.W(W)) u_stage (
                .clk  (clk),
                .rst  (rst),
                .adv  (start),
                .din  (stg[gi]),
                .dout (stg[gi+1])
            );
        end
    endgenerate

    // output word and overflow register together
    padc_pkg::padc_out_t out_q;
    padc_pkg::padc_out_t out_d;
    // load only on a start, so the word stands until the next one
    always_comb begin
        out_d = out_q;
        if (start) begin
            out_d.result_bits   = stg[padc_pkg::LATENCY-1];
            out_d.overflow_flag = (stg[padc_pkg::LATENCY-1] == padc_pkg::CODE_MAX) ||
                                  (stg[padc_pkg::LATENCY-1] == padc_pkg::CODE_MIN);
        end
    end

    // register word and flag as one, so they always change together
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_q <= '{result_bits: padc_pkg::RESULT_RST, overflow_flag: 1'b0};
        end else begin
            out_q <= out_d;
        end
    end

    // outputs come straight from the word register
    assign result_bits   = out_q.result_bits;
    assign overflow_flag = out_q.overflow_flag;

    // idle timer for dynamic logic refresh
    logic [31:0] idle_q;
    logic [31:0] idle_d;
    logic        refresh_q;
    logic        refresh_d;
    // a start wins over a due refresh, as the clock is running again
    always_comb begin
        idle_d    = idle_q;
        refresh_d = 1'b0;
        if (start) begin
            idle_d = '0;
        end else if (idle_q >= IDLE_CYCLES - 1) begin
            idle_d    = '0;      // restart for the next interval
            refresh_d = 1'b1;
        end else begin
            idle_d = idle_q + 32'h1;
        end
    end

    // register timer and refresh strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idle_q    <= '0;
            refresh_q <= 1'b0;
        end else begin
            idle_q    <= idle_d;
            refresh_q <= refresh_d;
        end
    end

    assign refresh = refresh_q;

    // helper for the refresh checks: cycles since the last start or refresh,
    // counted apart from the timer, so that a fault in the timer shows up
    logic [31:0] gap_q;  // cycles since a start or a refresh
    logic [31:0] gap_d;  // next helper count
    // next helper count; it stops one past the limit so it cannot wrap
    always_comb begin
        gap_d = gap_q;
        if (start) begin
            gap_d = '0;             // a start opens a new interval
        end else if (refresh_q) begin
            gap_d = 32'h1;          // first cycle after a refresh
        end else if (gap_q <= IDLE_CYCLES) begin
            gap_d = gap_q + 32'h1;  // count up to one past the limit
        end
    end

    // register the helper count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_q <= '0;
        end else begin
            gap_q <= gap_d;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // a rising level on the conversion clock
    sequence s_edge;
        $rose(conv_clk);
    endsequence

    // a start that moves the last stage's code into the output word:
    // top code, bottom code, or any code between them
    sequence s_load_max;
        start && (stg[padc_pkg::LATENCY-1] == padc_pkg::CODE_MAX);
    endsequence
    sequence s_load_min;
        start && (stg[padc_pkg::LATENCY-1] == padc_pkg::CODE_MIN);
    endsequence
    sequence s_load_mid;
        start && (stg[padc_pkg::LATENCY-1] != padc_pkg::CODE_MAX)
              && (stg[padc_pkg::LATENCY-1] != padc_pkg::CODE_MIN);
    endsequence

    // pipeline, output word, start detect, refresh strobe and idle timer

    chk_out_hold: assert property (!start |=> $stable(out_q))
        else $error("output changed without conversion start");
    chk_ovf_code: assert property (overflow_flag == ((result_bits == 12'h7ff) || (result_bits == 12'h800)))
        else $error("overflow flag disagrees with code");
    chk_edge_start: assert property (s_edge |-> start)
        else $error("rising edge not taken as start");
    chk_result_load: assert property (start |=> result_bits == $past(stg[2]))
        else $error("result not loaded from pipeline");
    chk_pipe_shift: assert property (start |=> stg[2] == $past(stg[1]) && stg[1] == $past(stg[0]))
        else $error("pipeline did not advance");
    chk_refresh_one: assert property (refresh |=> !refresh)
        else $error("refresh longer than one cycle");
    chk_idle_clear: assert property (start |=> idle_q == 0)
        else $error("idle timer not cleared by start");
    chk_stage_stable: assert property (!start |=> $stable(stg[1]))
        else $error("pipeline moved without start");

    // overflow against the loaded code, first stage load, refresh timing against the helper count and against starts
    chk_ovf_max: assert property (s_load_max |=> overflow_flag && (result_bits == 12'h7ff))
        else $error("top code loaded without overflow");
    chk_ovf_min: assert property (s_load_min |=> overflow_flag && (result_bits == 12'h800))
        else $error("bottom code loaded without overflow");
    chk_ovf_clear: assert property (s_load_mid |=> !overflow_flag)
        else $error("overflow set for an inner code");
    chk_stage_load: assert property (start |=> stg[1] == $past(stg[0]))
        else $error("sample not taken into first stage");
    chk_refresh_gap: assert property (refresh |-> gap_q == IDLE_CYCLES)
        else $error("refresh before the idle interval ran out");
    chk_refresh_due: assert property (gap_q <= IDLE_CYCLES)
        else $error("refresh missing after the idle interval");
    chk_refresh_start: assert property (start |=> !refresh)
        else $error("refresh raised on a conversion start");
endmodule
`default_nettype wire

/* File: tb/padc_cap_model.sv */
// capture logic model: drives the conversion clock and latches each word
`default_nettype none
module padc_cap_model (
    // clock, reset and run enable
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           run,
    // converter outputs
    input  wire logic [11:0]    result_bits,
    input  wire logic           overflow_flag,
    // conversion clock and captured word
    output logic                conv_clk,
    output padc_pkg::padc_out_t cap,
    output logic                cap_stb
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_q; // phase in an eight cycle period
    // 800 ns period, far above the slowest accurate rate
    assign conv_clk = run && !cnt_q[2];
    // clock stands still while stopped; word latched on each rising conversion
    // edge, the third such edge after a sample being where its word stands
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 3'h0;
            cap_stb <= 1'b0;
            cap <= '0;
        end else begin
            cnt_q <= run ? cnt_q + 3'h1 : 3'h0;
            cap_stb <= run && (cnt_q == 3'h0);
            if (run && (cnt_q == 3'h0)) begin
                cap <= '{result_bits, overflow_flag};
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/padc_top_tb.sv */
// self-checking bench for the converter output logic
`default_nettype none
module padc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int IDLE = 20; // shortened idle interval
    typedef logic signed [12:0] padc_ain_t;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic                run = 1'b0;
    logic                gain_sel = 1'b1;
    padc_ain_t           ain_pos = '0;
    padc_ain_t           ain_neg = '0;
    logic                conv_clk;
    logic [11:0]         result_bits;
    logic                overflow_flag;
    logic                refresh;
    padc_pkg::padc_out_t cap;
    logic                cap_stb;
    int                  bad_count = 0;
    int                  tests_run = 0;
    int                  cyc = 0;
    always #50 clk = ~clk;
    padc_top #(.IDLE_CYCLES(IDLE)) u_dut (.clk(clk), .rst(rst), .conv_clk(conv_clk), .gain_sel(gain_sel),
        .ain_pos(ain_pos), .ain_neg(ain_neg), .result_bits(result_bits), .overflow_flag(overflow_flag),
        .refresh(refresh));
    padc_cap_model u_cap (.clk(clk), .rst(rst), .run(run), .result_bits(result_bits),
        .overflow_flag(overflow_flag), .conv_clk(conv_clk), .cap(cap), .cap_stb(cap_stb));
    // compare and count
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // expected code: difference scaled by gain, saturated
    function automatic logic [11:0] exp_code(input padc_ain_t p, input padc_ain_t n, input logic g);
        int d;
        d = g ? (int'(p) - int'(n)) / 2 : int'(p) - int'(n);
        d = d > 2047 ? 2047 : (d < -2048 ? -2048 : d);
        return d[11:0];
    endfunction
    // eight samples then three flush starts; capture k holds sample k-3
    task automatic run_codes(input logic g, input padc_ain_t p[8], input padc_ain_t n[8]);
        logic [11:0] e;
        int j;
        gain_sel <= g;
        ain_pos <= p[0];
        ain_neg <= n[0];
        run <= 1'b1;
        for (int k = 0; k < 11; k++) begin
            do @(posedge clk); while (cap_stb !== 1'b1);
            if (k >= 3) begin
                e = exp_code(p[k-3], n[k-3], g);
                check(cap.result_bits, e);
                check({11'h0, cap.overflow_flag}, {11'h0, e == padc_pkg::CODE_MAX || e == padc_pkg::CODE_MIN});
            end
            j = k < 7 ? k + 1 : 7;
            ain_pos <= p[j];
            ain_neg <= n[j];
        end
        run <= 1'b0;
        @(posedge clk); // clock rests low a cycle before any next stream
        $display("stream with gain select %0d done", g);
    endtask
    // unity gain, both inputs moving, extreme codes and the top code's neighbour
    task automatic test_unity();
        run_codes(1'b1, '{2047, -2048, 5, -5, 1000, -1, 0, 2046}, '{-2047, 2048, -5, 5, -1000, 1, 0, -2046});
    endtask
    // double gain with saturation both ways
    task automatic test_double();
        run_codes(1'b0, '{4095, -4096, 1023, 0, -1, 100, 2047, -2048}, '{-4096, 4095, 0, -1024, 0, 50, 0, 0});
    endtask
    // stopped clock: refresh spacing and held word
    task automatic test_idle();
        logic [11:0] held;
        logic        held_ovf;
        int n;
        held = result_bits;
        held_ovf = overflow_flag;
        check(held, 12'h800);
        for (int r = 0; r < 2; r++) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (refresh !== 1'b1 && n < 4 * IDLE);
        end
        check(n[11:0], 12'(IDLE));
        check(result_bits, held);
        check({11'h0, overflow_flag}, {11'h0, held_ovf});
        check({11'h0, held_ovf}, 12'h001);
        $display("idle refresh test done");
    endtask
    // cycle ceiling against hangs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            stop_test();
        end
    end
    // reset, then the scenarios in turn
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(result_bits, padc_pkg::RESULT_RST);
        check({11'h0, overflow_flag}, 12'h000);
        check({11'h0, refresh}, 12'h000);
        test_unity();
        test_double();
        test_idle();
        stop_test();
    end
endmodule
`default_nettype wire
